// ==== adc_cfg_ctrl.sv ====
`timescale 1ns/100ps
// Behaviour
// [RL1] Channel field routes converter input, resets shorted
// [RL2] Reference field picks single-ended reference voltage
// [RL3] Oversampling code gives ratio 200/100/64/32
// [RL4] Attenuator field selects 0/6.02/9.54 dB
// [RL5] Continuous bit: single or repeated conversion
// [RL6] Bypass bit routes samples around filter
// [RL7] Bypass picks lower halves, else upper
// [RL8] Software discards 10 or 3 first samples
// [RL9] Software recalibrates after changing bypass
// [RL10] Rate bit: 1.6 or 0.8 MHz clock
// [RL11] Microphone enable drives clock out on GPIO
// [RL12] Done flag sets, clears on status read
// [RL13] Software writes zero to reserved bits
module adc_cfg_ctrl
   import adc_cfg_pkg::*;
(
   input  wire logic        CLOCK_IN,
   input  wire logic        SRST_IN,
   input  wire logic [7:0]  AWADDR_IN,
   input  wire logic        AWVALID_IN,
   output logic             AWREADY_OUT,
   input  wire logic [31:0] WDATA_IN,
   input  wire logic [3:0]  WSTRB_IN,
   input  wire logic        WVALID_IN,
   output logic             WREADY_OUT,
   output logic [1:0]       BRESP_OUT,
   output logic             BVALID_OUT,
   input  wire logic        BREADY_IN,
   input  wire logic [7:0]  ARADDR_IN,
   input  wire logic        ARVALID_IN,
   output logic             ARREADY_OUT,
   output logic [31:0]      RDATA_OUT,
   output logic [1:0]       RRESP_OUT,
   output logic             RVALID_OUT,
   input  wire logic        RREADY_IN,
   input  wire logic        CONV_DONE_IN,
   input  wire logic [15:0] CONV_DATA_IN,
   input  wire logic        CAL_DONE_IN,
   input  wire logic [15:0] CAL_DATA_IN,
   output converter_configuration_t            CONVERTER_CONFIGURATION_OUT,
   output logic [6:1]       SWITCH_OUT,
   output logic [7:0]       DECIM_OUT,
   output logic             PDM_CLOCK_PIN_OUT,
   output logic             PDM_CLOCK_PIN_OE_OUT,
   output logic             IRQ_OUT
);

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Configuration as a bus word; reserved bits read zero
   function automatic logic [31:0] converter_configuration_word(input converter_configuration_t c);
      logic [31:0] w;
      w = 32'h0;
      w[CH_LSB +: 3]  = c.chan;
      w[REF_LSB +: 2] = c.ref_sel;
      w[OSR_LSB +: 2] = c.oversampling_ratio_select;
      w[ATT_LSB +: 2] = c.atten;
      w[CONTINUOUS_CONVERSION_BIT]     = c.continuous_conversion;
      w[BYP_BIT]      = c.bypass;
      w[RATE_BIT]     = c.rate;
      w[MIC_BIT]      = c.mic_en;
      return w;
   endfunction

   wr_state_t   wr_state_q, wr_state_d;
   logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [7:0]  waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        do_write;
   logic        arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic        stat_rd;
   converter_configuration_t       converter_configuration_q, converter_configuration_d;
   logic [3:0]  stat_q, stat_d, mask_q, mask_d;
   logic [31:0] res_q, res_d, calv_q, calv_d, cw;
   logic [6:1]  sw_q, sw_d;
   logic [7:0]  decim_q, decim_d;
   logic        irq_q, irq_d;
   logic [5:0]  pdm_cnt_q, pdm_cnt_d, period;
   logic        pdm_q, pdm_d, oe_q, oe_d;

   // Write channel: address and data taken in either order
   always_comb begin
      wr_state_d = wr_state_q;
      aw_held_d  = aw_held_q;
      w_held_d   = w_held_q;
      waddr_d    = waddr_q;
      wdata_d    = wdata_q;
      wstrb_d    = wstrb_q;
      bvalid_d   = bvalid_q;
      bresp_d    = bresp_q;
      do_write   = 1'b0;
      if (AWVALID_IN && awready_q) begin
         aw_held_d = 1'b1;
         waddr_d   = AWADDR_IN;
      end
      if (WVALID_IN && wready_q) begin
         w_held_d = 1'b1;
         wdata_d  = WDATA_IN;
         wstrb_d  = WSTRB_IN;
      end
      unique case (wr_state_q)
         WR_COLLECT: begin
            if (aw_held_q && w_held_q) begin
               do_write   = 1'b1;
               aw_held_d  = 1'b0;
               w_held_d   = 1'b0;
               bvalid_d   = 1'b1;
               wr_state_d = WR_RESP;
               bresp_d    = (waddr_q inside {CONVERTER_CONFIGURATION_OFS, STAT_OFS, MASK_OFS, RES_OFS, CALV_OFS})
                            ? RESP_OK : RESP_ERR;
            end
         end
         WR_RESP: begin
            if (BREADY_IN) begin
               bvalid_d   = 1'b0;
               wr_state_d = WR_COLLECT;
            end
         end
      endcase
      awready_d = !aw_held_d && (wr_state_d == WR_COLLECT);
      wready_d  = !w_held_d && (wr_state_d == WR_COLLECT);
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN) begin
         wr_state_q <= WR_COLLECT;
         aw_held_q  <= 1'b0;
         w_held_q   <= 1'b0;
         waddr_q    <= 8'h00;
         wdata_q    <= 32'h0;
         wstrb_q    <= 4'h0;
         awready_q  <= 1'b0;
         wready_q   <= 1'b0;
         bvalid_q   <= 1'b0;
         bresp_q    <= RESP_OK;
      end else begin
         wr_state_q <= wr_state_d;
         aw_held_q  <= aw_held_d;
         w_held_q   <= w_held_d;
         waddr_q    <= waddr_d;
         wdata_q    <= wdata_d;
         wstrb_q    <= wstrb_d;
         awready_q  <= awready_d;
         wready_q   <= wready_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
      end
   end

   // Read channel: one read in flight, answered a cycle after the address
   always_comb begin
      arready_d = arready_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      stat_rd   = 1'b0;
      if (ARVALID_IN && arready_q) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rresp_d   = RESP_OK;
         unique case (ARADDR_IN)
            CONVERTER_CONFIGURATION_OFS: rdata_d = converter_configuration_word(converter_configuration_q);
            STAT_OFS: begin
               rdata_d = {28'h0, stat_q};
               stat_rd = 1'b1; // RL12
            end
            MASK_OFS: rdata_d = {28'h0, mask_q};
            RES_OFS:  rdata_d = res_q;
            CALV_OFS: rdata_d = calv_q;
            default: begin
               rdata_d = 32'h0;
               rresp_d = RESP_ERR;
            end
         endcase
      end else if (rvalid_q && RREADY_IN) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OK;
      end else begin
         arready_q <= arready_d || (!rvalid_d && !arready_q);
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // Register file, event flags and result placement
   always_comb begin
      converter_configuration_d = converter_configuration_q;
      mask_d = mask_q;
      res_d  = res_q;
      calv_d = calv_q;
      stat_d = stat_q;
      cw     = merge(converter_configuration_word(converter_configuration_q), wdata_q, wstrb_q);
      if (do_write) begin
         unique case (waddr_q)
            CONVERTER_CONFIGURATION_OFS: begin
               converter_configuration_d.chan    = cw[CH_LSB +: 3];   // RL1
               converter_configuration_d.ref_sel = cw[REF_LSB +: 2];  // RL2
               converter_configuration_d.oversampling_ratio_select     = cw[OSR_LSB +: 2];  // RL3
               converter_configuration_d.atten   = cw[ATT_LSB +: 2];  // RL4
               converter_configuration_d.continuous_conversion    = cw[CONTINUOUS_CONVERSION_BIT];      // RL5
               converter_configuration_d.bypass  = cw[BYP_BIT];       // RL6
               converter_configuration_d.rate    = cw[RATE_BIT];      // RL10
               converter_configuration_d.mic_en  = cw[MIC_BIT];       // RL11
            end
            STAT_OFS: stat_d = stat_q & ~(wdata_q[3:0] & {4{wstrb_q[0]}});
            MASK_OFS: mask_d = 4'(merge({28'h0, mask_q}, wdata_q, wstrb_q));
            CALV_OFS: calv_d = merge(calv_q, wdata_q, wstrb_q);
            default: ;
         endcase
      end
      // Reading status clears it; a flag raised the same cycle survives
      if (stat_rd) begin
         stat_d = 4'h0; // RL12
      end
      if (CONV_DONE_IN) begin
         stat_d[EOC_BIT] = 1'b1; // RL12
         res_d = converter_configuration_q.bypass ? {16'h0, CONV_DATA_IN} : {CONV_DATA_IN, 16'h0}; // RL7
      end
      if (CAL_DONE_IN) begin
         stat_d[CAL_BIT] = 1'b1;
         calv_d = converter_configuration_q.bypass ? {16'h0, CAL_DATA_IN} : {CAL_DATA_IN, 16'h0}; // RL7
      end
   end

   // Decoded outputs are registered from the next values so they track the fields
   always_comb begin
      unique case (converter_configuration_d.oversampling_ratio_select)
         2'h0: decim_d = DEC_200; // RL3
         2'h1: decim_d = DEC_100;
         2'h2: decim_d = DEC_64;
         2'h3: decim_d = DEC_32;
      endcase
      irq_d = |(stat_d & ~mask_d);
   end

   // One switch group per input code; code zero and seven leave all open
   for (genvar i = 1; i <= 6; i++) begin : g_sw
      assign sw_d[i] = (converter_configuration_d.chan == 3'(i)); // RL1
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN) begin
         converter_configuration_q         <= '0;
         converter_configuration_q.chan    <= CH_RST; // RL1
         mask_q         <= MASK_RST;
         stat_q         <= 4'h0;
         res_q          <= 32'h0;
         calv_q         <= 32'h0;
         sw_q           <= 6'h20;
         decim_q        <= DEC_200;
         irq_q          <= 1'b0;
      end else begin
         converter_configuration_q  <= converter_configuration_d;
         mask_q  <= mask_d;
         stat_q  <= stat_d;
         res_q   <= res_d;
         calv_q  <= calv_d;
         sw_q    <= sw_d;
         decim_q <= decim_d;
         irq_q   <= irq_d;
      end
   end

   // Microphone clock divider; odd fast period gives a 12/13 split, not exact 50%
   always_comb begin
      period    = converter_configuration_q.rate ? SLOW_CYC : FAST_CYC; // RL10
      pdm_cnt_d = (pdm_cnt_q >= period - 6'h01) ? 6'h00 : pdm_cnt_q + 6'h01;
      if (!converter_configuration_q.mic_en) begin
         pdm_cnt_d = 6'h00; // RL11
      end
      pdm_d = converter_configuration_q.mic_en && (pdm_cnt_d < (period >> 1)); // RL10
      oe_d  = converter_configuration_q.mic_en; // RL11
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN) begin
         pdm_cnt_q <= 6'h00;
         pdm_q     <= 1'b0;
         oe_q      <= 1'b0;
      end else begin
         pdm_cnt_q <= pdm_cnt_d;
         pdm_q     <= pdm_d;
         oe_q      <= oe_d;
      end
   end

   // Output wiring, all from flip-flops
   assign AWREADY_OUT    = awready_q;
   assign WREADY_OUT     = wready_q;
   assign BVALID_OUT     = bvalid_q;
   assign BRESP_OUT      = bresp_q;
   assign ARREADY_OUT    = arready_q;
   assign RVALID_OUT     = rvalid_q;
   assign RDATA_OUT      = rdata_q;
   assign RRESP_OUT      = rresp_q;
   assign CONVERTER_CONFIGURATION_OUT       = converter_configuration_q;
   assign SWITCH_OUT     = sw_q;
   assign DECIM_OUT      = decim_q;
   assign PDM_CLOCK_PIN_OUT    = pdm_q;
   assign PDM_CLOCK_PIN_OE_OUT = oe_q;
   assign IRQ_OUT        = irq_q;

   // Checks on the field decode, reset values, data placement and done flag
   a_chan_open: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL1
      (converter_configuration_q.chan == 3'h0) |-> (SWITCH_OUT == 6'h00))
      else $error("Switch closed with channel code zero");
   a_ref_reset: assert property (@(posedge CLOCK_IN) // RL2
      $fell(SRST_IN) |-> (converter_configuration_q.ref_sel == 2'h0 && converter_configuration_q.chan == CH_RST))
      else $error("Reference or channel wrong after reset");
   a_decim_ratio: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL3
      (converter_configuration_q.oversampling_ratio_select == 2'h3) |-> (DECIM_OUT == 8'h20))
      else $error("Decimation ratio not 32");
   a_continuous_conversion_write: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL5
      (do_write && waddr_q == CONVERTER_CONFIGURATION_OFS && wstrb_q[1]) |=> (converter_configuration_q.continuous_conversion == $past(wdata_q[11])))
      else $error("Continuous bit not written");
   a_bypass_write: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL6
      (do_write && waddr_q == CONVERTER_CONFIGURATION_OFS && wstrb_q[2]) |=> (converter_configuration_q.bypass == $past(wdata_q[18])))
      else $error("Bypass bit not written");
   a_result_half: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL7
      (CONV_DONE_IN && !converter_configuration_q.bypass) |=> (res_q == {$past(CONV_DATA_IN), 16'h0}))
      else $error("Filtered result not in upper half");
   a_pdm_rate: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL10
      ($rose(PDM_CLOCK_PIN_OUT) && !converter_configuration_q.rate && $stable(converter_configuration_q)) |-> PDM_CLOCK_PIN_OUT[*8])
      else $error("Fast microphone clock high phase too short");
   a_pdm_off: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL11
      !converter_configuration_q.mic_en |=> (!PDM_CLOCK_PIN_OE_OUT && !PDM_CLOCK_PIN_OUT))
      else $error("Microphone clock driven while disabled");
   a_done_flag: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN) // RL12
      CONV_DONE_IN |=> stat_q[2])
      else $error("Conversion done flag not set");
endmodule

// ==== adc_cfg_pkg.sv ====
package adc_cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] CONVERTER_CONFIGURATION_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] MASK_OFS = 8'h0c;
   localparam logic [7:0] RES_OFS  = 8'h14;
   localparam logic [7:0] CALV_OFS = 8'h18;
   // Configuration field positions
   localparam int CH_LSB   = 1;
   localparam int REF_LSB  = 4;
   localparam int OSR_LSB  = 6;
   localparam int ATT_LSB  = 8;
   localparam int CONTINUOUS_CONVERSION_BIT = 11;
   localparam int BYP_BIT  = 18;
   localparam int RATE_BIT = 20;
   localparam int MIC_BIT  = 22;
   // Status and mask bit positions
   localparam int CAL_BIT  = 0;
   localparam int EOC_BIT  = 2;
   // Reset values
   localparam logic [2:0] CH_RST   = 3'h6;
   localparam logic [3:0] MASK_RST = 4'hf;
   // Decimation ratios per oversampling code
   localparam logic [7:0] DEC_200 = 8'hc8;
   localparam logic [7:0] DEC_100 = 8'h64;
   localparam logic [7:0] DEC_64  = 8'h40;
   localparam logic [7:0] DEC_32  = 8'h20;
   // Microphone clock timing and bus response codes
   localparam int CLK_HZ      = 40_000_000;
   localparam int PDM_FAST_HZ = 1_600_000;
   localparam int PDM_SLOW_HZ = 800_000;
   localparam logic [5:0] FAST_CYC = 6'(CLK_HZ / PDM_FAST_HZ);
   localparam logic [5:0] SLOW_CYC = 6'(CLK_HZ / PDM_SLOW_HZ);
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef struct packed {
      logic       mic_en;
      logic       rate;
      logic       bypass;
      logic       continuous_conversion;
      logic [1:0] atten;
      logic [1:0] oversampling_ratio_select;
      logic [1:0] ref_sel;
      logic [2:0] chan;
   } converter_configuration_t;

   typedef enum logic [0:0] {
      WR_COLLECT = 1'b0,
      WR_RESP    = 1'b1
   } wr_state_t;
endpackage

// ==== conv_model.sv ====
`timescale 1ns/100ps
// Far-side converter: answers a fire request after lat cycles with one done pulse
module conv_model (
   input  wire logic        clk_in,
   input  wire logic        fire_conv_in,
   input  wire logic        fire_cal_in,
   input  wire logic [15:0] val_in,
   input  wire logic [7:0]  lat_in,
   output logic             conv_done_out = 1'b0,
   output logic             cal_done_out  = 1'b0,
   output logic [15:0]      conv_data_out = 16'h0000,
   output logic [15:0]      cal_data_out  = 16'h0000
);
   logic [7:0]  cnt_q  = 8'h00;
   logic        kind_q = 1'b0;
   logic [15:0] last_q = 16'h0000;

   // Data lines show the inverse of the last word outside the pulse, never a stale match
   always_ff @(posedge clk_in) begin
      conv_done_out <= 1'b0;
      cal_done_out  <= 1'b0;
      conv_data_out <= ~last_q;
      cal_data_out  <= ~last_q;
      if (fire_conv_in || fire_cal_in) begin
         cnt_q  <= lat_in;
         kind_q <= fire_cal_in;
         last_q <= val_in;
      end else if (cnt_q == 8'h01) begin
         cnt_q <= 8'h00;
         if (kind_q) begin
            cal_done_out <= 1'b1;
            cal_data_out <= last_q;
         end else begin
            conv_done_out <= 1'b1;
            conv_data_out <= last_q;
         end
      end else if (cnt_q > 8'h01) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

// ==== tb_adc_cfg_ctrl.sv ====
`timescale 1ns/100ps
module tb_adc_cfg_ctrl;
   import adc_cfg_pkg::*;
   logic clk = 1'b0, srst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h01;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, irq, pdm, pdm_oe;
   logic [1:0] bresp, rresp;
   logic fire_conv = 1'b0, fire_cal = 1'b0, conv_done, cal_done;
   logic [15:0] val = 16'h0, conv_data, cal_data;
   converter_configuration_t converter_configuration;
   logic [6:1] sw;
   logic [7:0] decim;
   int fails = 0, tests_run = 0;

   // Clock at 40 MHz
   initial begin
      forever #12.5 clk = ~clk;
   end

   adc_cfg_ctrl DUT (.CLOCK_IN(clk), .SRST_IN(srst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
      .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
      .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
      .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
      .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .CONV_DONE_IN(conv_done),
      .CONV_DATA_IN(conv_data), .CAL_DONE_IN(cal_done), .CAL_DATA_IN(cal_data),
      .CONVERTER_CONFIGURATION_OUT(converter_configuration), .SWITCH_OUT(sw), .DECIM_OUT(decim), .PDM_CLOCK_PIN_OUT(pdm),
      .PDM_CLOCK_PIN_OE_OUT(pdm_oe), .IRQ_OUT(irq));

   conv_model partner (.clk_in(clk), .fire_conv_in(fire_conv), .fire_cal_in(fire_cal),
      .val_in(val), .lat_in(lat), .conv_done_out(conv_done), .cal_done_out(cal_done),
      .conv_data_out(conv_data), .cal_data_out(cal_data));

   // Comparison of any result, widened to one word
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge clk);
         if (awready === 1'b1) aw_p = 1'b0;
         if (wready === 1'b1) w_p = 1'b0;
         if (!aw_p) awvalid <= 1'b0;
         if (!w_p) wvalid <= 1'b0;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // Let an edge pass so a following write never re-raises bready in this step
      @(posedge clk);
   endtask

   // Read: address held until taken, rready held until data seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(r, RESP_OK);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, exp);
   endtask

   // Fire one converter event, wait for its pulse, then let status and irq settle
   task automatic fire(input logic cal, input logic [15:0] v, input logic [7:0] l);
      int n;
      n = 0;
      val <= v; lat <= l; fire_conv <= !cal; fire_cal <= cal;
      @(posedge clk);
      fire_conv <= 1'b0; fire_cal <= 1'b0;
      while (conv_done !== 1'b1 && cal_done !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
   endtask

   task automatic t_reset();
      rd_chk(CONVERTER_CONFIGURATION_OFS, 32'h0000000c);
      rd_chk(MASK_OFS, 32'h0000000f);
      chk(sw, 6'h20);
      chk(decim, 8'hc8);
      chk({pdm_oe, pdm, irq}, 3'h0);
   endtask

   // Every channel code and every two-bit field code, reserved bits left zero
   task automatic t_fields();
      logic [7:0] dec_tab [4];
      dec_tab = '{8'hc8, 8'h64, 8'h40, 8'h20};
      for (int i = 0; i < 8; i++) begin
         wr_ok(CONVERTER_CONFIGURATION_OFS, 32'(i) << CH_LSB);
         chk(sw, (i >= 1 && i <= 6) ? 6'(1 << (i - 1)) : 6'h00);
      end
      for (int i = 0; i < 4; i++) begin
         wr_ok(CONVERTER_CONFIGURATION_OFS, (32'(i) << REF_LSB) | (32'(i) << OSR_LSB) | (32'(i) << ATT_LSB)
               | (32'(i % 2) << CONTINUOUS_CONVERSION_BIT) | (32'(i % 2) << BYP_BIT));
         chk(decim, dec_tab[i]);
         chk({converter_configuration.ref_sel, converter_configuration.atten}, {2'(i), 2'(i)});
         chk({converter_configuration.continuous_conversion, converter_configuration.bypass}, {1'(i % 2), 1'(i % 2)});
      end
      wr_ok(CONVERTER_CONFIGURATION_OFS, 32'h00540bfe);
      rd_chk(CONVERTER_CONFIGURATION_OFS, 32'h00540bfe);
      chk(converter_configuration, 13'h1fff);
   endtask

   // Result and calibration halves follow the bypass bit, recalibrating after each change
   task automatic t_halves();
      wr_ok(CONVERTER_CONFIGURATION_OFS, 32'h0);
      fire(1'b1, 16'h5a3c, 8'h01);
      fire(1'b0, 16'h1234, 8'h14);
      rd_chk(RES_OFS, 32'h12340000);
      rd_chk(CALV_OFS, 32'h5a3c0000);
      wr_ok(CONVERTER_CONFIGURATION_OFS, 32'h1 << BYP_BIT);
      fire(1'b1, 16'hc3a5, 8'h02);
      fire(1'b0, 16'h8765, 8'h01);
      rd_chk(RES_OFS, 32'h00008765);
      rd_chk(CALV_OFS, 32'h0000c3a5);
      // Continuous run with the filter bypassed: software drops the first three samples
      wr_ok(CONVERTER_CONFIGURATION_OFS, (32'h1 << BYP_BIT) | (32'h1 << CONTINUOUS_CONVERSION_BIT));
      for (int i = 0; i < 3; i++) begin
         fire(1'b0, 16'(i), 8'h01);
      end
      fire(1'b0, 16'h0ace, 8'h01);
      rd_chk(RES_OFS, 32'h00000ace);
   endtask

   // Done flag and its clear on read, clear of the calibration flag by write, and masking of the interrupt
   task automatic t_status();
      rd_chk(STAT_OFS, 32'h5);
      wr_ok(MASK_OFS, 32'h0);
      fire(1'b0, 16'h0001, 8'h01);
      chk(irq, 1'b1);
      rd_chk(STAT_OFS, 32'h4);
      rd_chk(STAT_OFS, 32'h0);
      chk(irq, 1'b0);
      wr_ok(MASK_OFS, 32'hf);
      fire(1'b1, 16'h0002, 8'h03);
      chk(irq, 1'b0);
      wr_ok(STAT_OFS, 32'h1);
      rd_chk(STAT_OFS, 32'h0);
   endtask

   // Period of the microphone clock, counted rising edge to rising edge
   task automatic pdm_period(output int p);
      int n;
      n = 0;
      p = 0;
      while (pdm !== 1'b0 && n < 200) begin @(posedge clk); n++; end
      while (pdm !== 1'b1 && n < 200) begin @(posedge clk); n++; end
      while (pdm !== 1'b0 && n < 200) begin @(posedge clk); n++; p++; end
      while (pdm !== 1'b1 && n < 200) begin @(posedge clk); n++; p++; end
   endtask

   task automatic t_pdm();
      int p;
      wr_ok(CONVERTER_CONFIGURATION_OFS, 32'h1 << MIC_BIT);
      pdm_period(p);
      chk(p, CLK_HZ / 1_600_000);
      chk(pdm_oe, 1'b1);
      wr_ok(CONVERTER_CONFIGURATION_OFS, (32'h1 << MIC_BIT) | (32'h1 << RATE_BIT));
      pdm_period(p);
      chk(p, CLK_HZ / 800_000);
      wr_ok(CONVERTER_CONFIGURATION_OFS, 32'h0);
      repeat (60) @(posedge clk);
      chk({pdm_oe, pdm}, 2'h0);
   endtask

   // Unmapped place is refused and leaves the configuration alone
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h40, 32'hffffffff, r);
      chk(r, RESP_ERR);
      rd(8'h40, d, r);
      chk({30'h0, r}, RESP_ERR);
      chk(d, 32'h0);
      rd_chk(CONVERTER_CONFIGURATION_OFS, 32'h0);
      // Only byte lane two lands: bypass, rate and microphone enable
      wstrb <= 4'h4;
      wr_ok(CONVERTER_CONFIGURATION_OFS, 32'h00540bfe);
      wstrb <= 4'hf;
      rd_chk(CONVERTER_CONFIGURATION_OFS, 32'h00540000);
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence: reset for 16 cycles, then the scenarios
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_fields();
      t_halves();
      t_status();
      t_pdm();
      t_unmapped();
      give_verdict();
   end

   // Watchdog, well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict();
   end
endmodule
